// ### hw/ilcgd_detector.sv
`timescale 1ns/10ps
`default_nettype none
module ilcgd_detector #(
  parameter int INTEG_CYCLES = ilcgd_pkg::INTEG_CYCLES,
  parameter int CNT_W        = ilcgd_pkg::CNT_W
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Received bits
  input wire logic        bit_stb_i,
  input wire logic        bit_i,
  // Programming
  input wire logic [2:0]  len_sel_i,
  input wire logic [15:0] code_i,
  // Result
  output logic            seen_o
);
  localparam int SH = ilcgd_pkg::ERR_SHIFT;
  localparam int TW = $clog2(INTEG_CYCLES);

  if (INTEG_CYCLES < 2 || CNT_W < 4) begin : g_chk
    $error("ilcgd_detector: integration window or counter too small");
  end

  ilcgd_pkg::ilcgd_det_state_type state_ff;
  ilcgd_pkg::ilcgd_det_state_type nxt_state;
  logic [15:0]         hist_ff;
  logic [15:0]         nxt_hist;
  logic [3:0]          phase_ff;
  logic [3:0]          nxt_phase;
  logic [CNT_W-1:0]    bits_ff;
  logic [CNT_W-1:0]    nxt_bits;
  logic [CNT_W-1:0]    err_ff;
  logic [CNT_W-1:0]    nxt_err;
  logic [TW-1:0]       timer_ff;
  logic [TW-1:0]       nxt_timer;
  logic                seen_ff;
  logic                nxt_seen;
  logic [4:0]          len;
  logic [15:0]         hit;
  logic                win_end;
  logic                pass;

  // Code 111 covers 8-bit codes too, as two copies fill the 16-bit word
  assign len = (len_sel_i == ilcgd_pkg::RX_SEL_16) ? ilcgd_pkg::LEN_16
             : 5'(len_sel_i) + 5'h01;

  // Last len bits equal the code, first code bit oldest
  for (genvar j = 0; j < 16; j++) begin : g_hit
    assign hit[j] = (5'(j) >= len) ||
                    (nxt_hist[j] == code_i[4'(5'h10 - len + 5'(j))]);
  end

  assign win_end = (timer_ff == TW'(INTEG_CYCLES - 1));
  // Error share under one in 2**SH bits tolerates line errors
  assign pass    = (state_ff == ilcgd_pkg::DET_LOCK) && (bits_ff != '0) &&
                   ({err_ff, {SH{1'b0}}} < {{SH{1'b0}}, bits_ff});
  assign seen_o  = seen_ff;

  always_comb begin
    nxt_hist  = bit_stb_i ? {hist_ff[14:0], bit_i} : hist_ff;
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    nxt_bits  = bits_ff;
    nxt_err   = err_ff;
    nxt_seen  = seen_ff;
    nxt_timer = win_end ? '0 : timer_ff + 1'b1;
    if (bit_stb_i) begin
      case (state_ff)
        ilcgd_pkg::DET_HUNT: begin
          if (&hit) begin
            nxt_state = ilcgd_pkg::DET_LOCK;
            nxt_phase = '0;
          end
        end
        ilcgd_pkg::DET_LOCK: begin
          if (bit_i != code_i[4'hF - phase_ff] && err_ff != '1) begin
            nxt_err = err_ff + 1'b1;
          end
          if (bits_ff != '1) begin
            nxt_bits = bits_ff + 1'b1;
          end
          nxt_phase = (phase_ff == 4'(len - 5'h01)) ? 4'h0 : phase_ff + 4'h1;
        end
        default: nxt_state = ilcgd_pkg::DET_HUNT;
      endcase
    end
    // Verdict once per integration window
    if (win_end) begin
      nxt_seen = pass;
      nxt_bits = '0;
      nxt_err  = '0;
      if (!pass) begin
        nxt_state = ilcgd_pkg::DET_HUNT;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ilcgd_pkg::DET_HUNT;
      hist_ff  <= '0;
      phase_ff <= '0;
      bits_ff  <= '0;
      err_ff   <= '0;
      timer_ff <= '0;
      seen_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      hist_ff  <= nxt_hist;
      phase_ff <= nxt_phase;
      bits_ff  <= nxt_bits;
      err_ff   <= nxt_err;
      timer_ff <= nxt_timer;
      seen_ff  <= nxt_seen;
    end
  end
endmodule
`default_nettype wire

// ### hw/ilcgd_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module ilcgd_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic    clk_i,
  input wire logic    rst_i,
  // Streams
  ilcgd_stream_if.snk in_s,
  ilcgd_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("ilcgd_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_ff  [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    nxt_wr;
  logic [AW-1:0]    rd_ff;
  logic [AW-1:0]    nxt_rd;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic             push;
  logic             pop;

  assign in_s.ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_ff != '0);
  assign out_s.data  = mem_ff[rd_ff];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_comb begin
    nxt_mem = mem_ff;
    if (push) begin
      nxt_mem[wr_ff] = in_s.data;
    end
    nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    mem_ff <= nxt_mem;
    if (rst_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule
`default_nettype wire

// ### hw/ilcgd_pkg.sv
package ilcgd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL   = 6'h0A;
  localparam logic [5:0] IDX_TX_LO  = 6'h0B;
  localparam logic [5:0] IDX_TX_HI  = 6'h0C;
  localparam logic [5:0] IDX_UP_LO  = 6'h0D;
  localparam logic [5:0] IDX_UP_HI  = 6'h0E;
  localparam logic [5:0] IDX_DN_LO  = 6'h0F;
  localparam logic [5:0] IDX_DN_HI  = 6'h10;
  localparam logic [5:0] IDX_STATUS = 6'h11;
  localparam logic [5:0] IDX_CONFIG = 6'h12;

  // Control register fields
  localparam int TX_LEN_MSB = 7;
  localparam int TX_LEN_LSB = 6;
  localparam int UP_LEN_MSB = 5;
  localparam int UP_LEN_LSB = 3;
  localparam int DN_LEN_MSB = 2;
  localparam int DN_LEN_LSB = 0;

  // Status and config fields
  localparam int STAT_UP_BIT  = 7;
  localparam int STAT_DN_BIT  = 6;
  localparam int STAT_RLB_BIT = 0;
  localparam int CFG_TX_EN_BIT = 0;
  localparam int CFG_AUTO_BIT  = 1;

  localparam logic [7:0] REG_RST = 8'h00;

  // Transmit and receive length encodings and lengths
  localparam logic [1:0] TX_SEL_5  = 2'h0;
  localparam logic [1:0] TX_SEL_6  = 2'h1;
  localparam logic [1:0] TX_SEL_7  = 2'h2;
  localparam logic [4:0] LEN_5     = 5'h05;
  localparam logic [4:0] LEN_6     = 5'h06;
  localparam logic [4:0] LEN_7     = 5'h07;
  localparam logic [4:0] LEN_16    = 5'h10;
  localparam logic [2:0] RX_SEL_16 = 3'h7;

  // Timing
  localparam int CLK_HZ        = 50000000;
  localparam int INTEG_MS      = 48;
  localparam int INTEG_CYCLES  = INTEG_MS * (CLK_HZ / 1000);
  localparam int LOOP_S        = 5;
  localparam int LOOP_CYCLES   = LOOP_S * CLK_HZ;

  // Error tolerance: errors times 2**ERR_SHIFT must stay below bits seen
  localparam int ERR_SHIFT = 5;
  localparam int CNT_W     = 20;

  typedef enum logic {DET_HUNT, DET_LOCK} ilcgd_det_state_type;
endpackage

// ### hw/ilcgd_stream_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ilcgd_stream_if #(parameter int WIDTH = 1);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### hw/ilcgd_top.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Generate 5/6/7 or 16-bit and detect 1-7 or 16-bit patterns
// - Tx length field 7:6 selects 5/6/7/16 bits
// - Lengths 5/6/7 use only low tx code
// - Low code bit 7 sent first, descending
// - Two independent detectors: loop-up and loop-down
// - Detector lengths from fields 5:3 and 2:0
// - Detection survives one error per hundred bits
// - About 48 ms integration sets status bits 7/6
// - Auto loopback after five seconds of codes
module ilcgd_top #(
  parameter int INTEG_CYCLES = ilcgd_pkg::INTEG_CYCLES,
  parameter int LOOP_CYCLES  = ilcgd_pkg::LOOP_CYCLES,
  parameter int FIFO_DEPTH   = 4
) (
  // Clock and reset
  input wire logic         clk_i,
  input wire logic         rst_i,
  // Wishbone slave
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_we_i,
  input wire logic [7:0]   wb_adr_i,
  input wire logic [3:0]   wb_sel_i,
  input wire logic [31:0]  wb_dat_i,
  output logic     [31:0]  wb_dat_o,
  output logic             wb_ack_o,
  // Transmit line
  input wire logic         tx_clk_i,
  output logic             tx_data_o,
  // Receive line
  input wire logic         rx_clk_i,
  input wire logic         rx_data_i,
  // Loopback state
  output logic             remote_loop_o
);
  localparam int LW = $clog2(LOOP_CYCLES);

  if (LOOP_CYCLES < 2 || FIFO_DEPTH < 2) begin : g_chk
    $error("ilcgd_top: LOOP_CYCLES and FIFO_DEPTH must be at least 2");
  end

  // Register file
  logic [7:0]  ctrl_ff;
  logic [7:0]  nxt_ctrl;
  logic [7:0]  txlo_ff;
  logic [7:0]  nxt_txlo;
  logic [7:0]  txhi_ff;
  logic [7:0]  nxt_txhi;
  logic [7:0]  uplo_ff;
  logic [7:0]  nxt_uplo;
  logic [7:0]  uphi_ff;
  logic [7:0]  nxt_uphi;
  logic [7:0]  dnlo_ff;
  logic [7:0]  nxt_dnlo;
  logic [7:0]  dnhi_ff;
  logic [7:0]  nxt_dnhi;
  logic [7:0]  cfg_ff;
  logic [7:0]  nxt_cfg;
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic        access;
  logic        wr_en;
  logic [5:0]  idx;
  logic [7:0]  rd_val;
  logic [7:0]  status;

  // Generator
  logic [3:0]  gidx_ff;
  logic [3:0]  nxt_gidx;
  logic [4:0]  tx_len;
  logic [15:0] tx_word;
  logic        tx_en;

  // Line synchronisers
  logic        txc_m_ff;
  logic        txc_s_ff;
  logic        txc_d_ff;
  logic        rxc_m_ff;
  logic        rxc_s_ff;
  logic        rxc_d_ff;
  logic        rxd_m_ff;
  logic        rxd_s_ff;
  logic        rx_last_ff;
  logic        nxt_rx_last;
  logic        txd_ff;
  logic        nxt_txd;
  logic        tx_edge;
  logic        rx_stb;

  // Auto remote loopback
  logic          rlb_ff;
  logic          nxt_rlb;
  logic [LW-1:0] hold_ff;
  logic [LW-1:0] nxt_hold;
  logic          auto_en;
  logic          up_seen;
  logic          dn_seen;

  ilcgd_stream_if #(.WIDTH(1)) gen_s ();
  ilcgd_stream_if #(.WIDTH(1)) line_s ();

  // Bus slave: one wait state, ack drops after one cycle
  assign access = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign idx    = wb_adr_i[7:2];
  assign wr_en  = access & wb_we_i & wb_sel_i[0] & (wb_adr_i[1:0] == 2'h0);

  always_comb begin
    status                          = 8'h00;
    status[ilcgd_pkg::STAT_UP_BIT]  = up_seen;
    status[ilcgd_pkg::STAT_DN_BIT]  = dn_seen;
    status[ilcgd_pkg::STAT_RLB_BIT] = rlb_ff;
    rd_val = 8'h00;
    if (wb_adr_i[1:0] == 2'h0) begin
      case (idx)
        ilcgd_pkg::IDX_CTRL:   rd_val = ctrl_ff;
        ilcgd_pkg::IDX_TX_LO:  rd_val = txlo_ff;
        ilcgd_pkg::IDX_TX_HI:  rd_val = txhi_ff;
        ilcgd_pkg::IDX_UP_LO:  rd_val = uplo_ff;
        ilcgd_pkg::IDX_UP_HI:  rd_val = uphi_ff;
        ilcgd_pkg::IDX_DN_LO:  rd_val = dnlo_ff;
        ilcgd_pkg::IDX_DN_HI:  rd_val = dnhi_ff;
        ilcgd_pkg::IDX_STATUS: rd_val = status;
        ilcgd_pkg::IDX_CONFIG: rd_val = cfg_ff;
        default:               rd_val = 8'h00;
      endcase
    end
    nxt_ack  = access;
    nxt_rdat = access ? {24'h000000, rd_val} : rdat_ff;
    nxt_ctrl = ctrl_ff;
    nxt_txlo = txlo_ff;
    nxt_txhi = txhi_ff;
    nxt_uplo = uplo_ff;
    nxt_uphi = uphi_ff;
    nxt_dnlo = dnlo_ff;
    nxt_dnhi = dnhi_ff;
    nxt_cfg  = cfg_ff;
    if (wr_en) begin
      case (idx)
        ilcgd_pkg::IDX_CTRL:   nxt_ctrl = wb_dat_i[7:0];
        ilcgd_pkg::IDX_TX_LO:  nxt_txlo = wb_dat_i[7:0];
        ilcgd_pkg::IDX_TX_HI:  nxt_txhi = wb_dat_i[7:0];
        ilcgd_pkg::IDX_UP_LO:  nxt_uplo = wb_dat_i[7:0];
        ilcgd_pkg::IDX_UP_HI:  nxt_uphi = wb_dat_i[7:0];
        ilcgd_pkg::IDX_DN_LO:  nxt_dnlo = wb_dat_i[7:0];
        ilcgd_pkg::IDX_DN_HI:  nxt_dnhi = wb_dat_i[7:0];
        ilcgd_pkg::IDX_CONFIG: nxt_cfg  = wb_dat_i[7:0];
        default:               nxt_cfg  = cfg_ff;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h00000000;
      ctrl_ff <= ilcgd_pkg::REG_RST;
      txlo_ff <= ilcgd_pkg::REG_RST;
      txhi_ff <= ilcgd_pkg::REG_RST;
      uplo_ff <= ilcgd_pkg::REG_RST;
      uphi_ff <= ilcgd_pkg::REG_RST;
      dnlo_ff <= ilcgd_pkg::REG_RST;
      dnhi_ff <= ilcgd_pkg::REG_RST;
      cfg_ff  <= ilcgd_pkg::REG_RST;
    end else begin
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
      ctrl_ff <= nxt_ctrl;
      txlo_ff <= nxt_txlo;
      txhi_ff <= nxt_txhi;
      uplo_ff <= nxt_uplo;
      uphi_ff <= nxt_uphi;
      dnlo_ff <= nxt_dnlo;
      dnhi_ff <= nxt_dnhi;
      cfg_ff  <= nxt_cfg;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // Generator: feeds the FIFO one pattern bit per accepted handshake
  assign tx_en   = cfg_ff[ilcgd_pkg::CFG_TX_EN_BIT];
  assign tx_word = {txlo_ff, txhi_ff};

  always_comb begin
    case (ctrl_ff[ilcgd_pkg::TX_LEN_MSB:ilcgd_pkg::TX_LEN_LSB])
      ilcgd_pkg::TX_SEL_5: tx_len = ilcgd_pkg::LEN_5;
      ilcgd_pkg::TX_SEL_6: tx_len = ilcgd_pkg::LEN_6;
      ilcgd_pkg::TX_SEL_7: tx_len = ilcgd_pkg::LEN_7;
      default:             tx_len = ilcgd_pkg::LEN_16;
    endcase
    nxt_gidx = gidx_ff;
    if (!tx_en) begin
      nxt_gidx = 4'h0;
    end else if (gen_s.ready) begin
      // Wrap straight to the first bit so repetitions abut
      nxt_gidx = (gidx_ff == 4'(tx_len - 5'h01)) ? 4'h0 : gidx_ff + 4'h1;
    end
  end

  // Lengths up to 7 never index past the low code byte
  assign gen_s.valid = tx_en;
  assign gen_s.data  = tx_word[4'hF - gidx_ff];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gidx_ff <= 4'h0;
    end else begin
      gidx_ff <= nxt_gidx;
    end
  end

  ilcgd_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .in_s  (gen_s),
    .out_s (line_s)
  );

  // Line pins: two flops each, then edge detection on the second stage
  assign tx_edge      = txc_s_ff & ~txc_d_ff;
  assign rx_stb       = rxc_s_ff & ~rxc_d_ff;
  assign line_s.ready = tx_edge;

  always_comb begin
    nxt_rx_last = rx_stb ? rxd_s_ff : rx_last_ff;
    nxt_txd     = txd_ff;
    if (tx_edge) begin
      nxt_txd = rlb_ff ? rx_last_ff : (line_s.valid & line_s.data);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txc_m_ff   <= 1'b0;
      txc_s_ff   <= 1'b0;
      txc_d_ff   <= 1'b0;
      rxc_m_ff   <= 1'b0;
      rxc_s_ff   <= 1'b0;
      rxc_d_ff   <= 1'b0;
      rxd_m_ff   <= 1'b0;
      rxd_s_ff   <= 1'b0;
      rx_last_ff <= 1'b0;
      txd_ff     <= 1'b0;
    end else begin
      txc_m_ff   <= tx_clk_i;
      txc_s_ff   <= txc_m_ff;
      txc_d_ff   <= txc_s_ff;
      rxc_m_ff   <= rx_clk_i;
      rxc_s_ff   <= rxc_m_ff;
      rxc_d_ff   <= rxc_s_ff;
      rxd_m_ff   <= rx_data_i;
      rxd_s_ff   <= rxd_m_ff;
      rx_last_ff <= nxt_rx_last;
      txd_ff     <= nxt_txd;
    end
  end

  assign tx_data_o = txd_ff;

  // Both detectors run side by side on the same received bits
  ilcgd_detector #(
    .INTEG_CYCLES (INTEG_CYCLES),
    .CNT_W        (ilcgd_pkg::CNT_W)
  ) u_det_up (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .bit_stb_i (rx_stb),
    .bit_i     (rxd_s_ff),
    .len_sel_i (ctrl_ff[ilcgd_pkg::UP_LEN_MSB:ilcgd_pkg::UP_LEN_LSB]),
    .code_i    ({uplo_ff, uphi_ff}),
    .seen_o    (up_seen)
  );

  ilcgd_detector #(
    .INTEG_CYCLES (INTEG_CYCLES),
    .CNT_W        (ilcgd_pkg::CNT_W)
  ) u_det_dn (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .bit_stb_i (rx_stb),
    .bit_i     (rxd_s_ff),
    .len_sel_i (ctrl_ff[ilcgd_pkg::DN_LEN_MSB:ilcgd_pkg::DN_LEN_LSB]),
    .code_i    ({dnlo_ff, dnhi_ff}),
    .seen_o    (dn_seen)
  );

  // Auto loopback: the relevant flag must hold unbroken for the full hold time
  assign auto_en = cfg_ff[ilcgd_pkg::CFG_AUTO_BIT];

  always_comb begin
    nxt_rlb  = rlb_ff;
    nxt_hold = hold_ff;
    if (!auto_en) begin
      nxt_rlb  = 1'b0;
      nxt_hold = '0;
    end else if ((!rlb_ff && up_seen) || (rlb_ff && dn_seen)) begin
      if (hold_ff == LW'(LOOP_CYCLES - 1)) begin
        nxt_rlb  = ~rlb_ff;
        nxt_hold = '0;
      end else begin
        nxt_hold = hold_ff + 1'b1;
      end
    end else begin
      nxt_hold = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rlb_ff  <= 1'b0;
      hold_ff <= '0;
    end else begin
      rlb_ff  <= nxt_rlb;
      hold_ff <= nxt_hold;
    end
  end

  assign remote_loop_o = rlb_ff;
endmodule
`default_nettype wire

// ### test/ilcgd_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ilcgd_checker #(
  parameter int INTEG_CYCLES = 2000,
  parameter int LOOP_CYCLES  = 500
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Line pins and loopback
  input wire logic        tx_clk_i,
  input wire logic        tx_data_o,
  input wire logic        rx_clk_i,
  input wire logic        rx_data_i,
  input wire logic        remote_loop_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Saturating age since reset, so a very long run cannot wrap it
  logic [31:0] since_ff;
  logic [31:0] nxt_since;
  always_comb begin
    nxt_since = (since_ff == 32'hFFFFFFFF) ? since_ff : since_ff + 32'h1;
    if (rst_i) begin
      nxt_since = 32'h0;
    end
  end
  always_ff @(posedge clk_i) begin
    since_ff <= nxt_since;
  end

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack lasted more than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("bus ack without a request");
  read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  misalign_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0
                                    |-> wb_dat_o == 32'h0)
    else $error("misaligned read returned data");
  dat_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data changed outside an answer");
  tx_quiet_a: assert property (!tx_clk_i && !$past(tx_clk_i) && !$past(tx_clk_i, 2)
                               && !remote_loop_o && !$past(remote_loop_o)
                               && !$past(remote_loop_o, 2) |-> $stable(tx_data_o))
    else $error("transmit bit changed away from its line clock edge");
  reset_idle_a: assert property ($fell(rst_i) |-> !wb_ack_o && !tx_data_o && !remote_loop_o
                                 && wb_dat_o == 32'h0)
    else $error("outputs not idle after reset");
  loop_delay_a: assert property ($rose(remote_loop_o) |-> since_ff > INTEG_CYCLES + LOOP_CYCLES)
    else $error("remote loopback entered too early");
endmodule

bind ilcgd_top ilcgd_checker #(
  .INTEG_CYCLES(INTEG_CYCLES),
  .LOOP_CYCLES (LOOP_CYCLES)
) ilcgd_checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_clk_i(tx_clk_i), .tx_data_o(tx_data_o),
  .rx_clk_i(rx_clk_i), .rx_data_i(rx_data_i), .remote_loop_o(remote_loop_o)
);
`default_nettype wire

// ### test/ilcgd_far_end.sv
`timescale 1ns/10ps
`default_nettype none
module ilcgd_far_end (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Pattern sent towards the device
  input wire logic [15:0] pat_i,
  input wire logic [4:0]  len_i,
  input wire logic [7:0]  err_gap_i,
  // Line pins
  input wire logic        tx_data_i,
  output logic            tx_clk_o,
  output logic            rx_clk_o,
  output logic            rx_data_o,
  // Captured transmit bits, newest in bit 0
  output logic [63:0]     hist_o,
  output logic [7:0]      cnt_o
);
  logic [3:0] div_ff = 4'h0;
  logic [4:0] pos_ff = 5'h0;
  logic [7:0] err_ff = 8'h0;
  initial begin
    tx_clk_o = 1'b0;
    rx_clk_o = 1'b0;
    rx_data_o = 1'b0;
  end
  // Line clocks run free as on a live span; ten system clocks a bit, rx phase offset
  always @(posedge clk_i) begin
    div_ff <= (div_ff == 4'h9) ? 4'h0 : div_ff + 4'h1;
    tx_clk_o <= (div_ff < 4'h5);
    rx_clk_o <= (div_ff >= 4'h3) && (div_ff < 4'h8);
    if (div_ff == 4'h8) begin
      // One flipped bit every err_gap_i bits, zero keeps the line clean
      rx_data_o <= pat_i[4'hF - pos_ff[3:0]] ^ (err_gap_i != 8'h0 && err_ff == err_gap_i - 8'h1);
      pos_ff <= (pos_ff + 5'h1 >= len_i) ? 5'h0 : pos_ff + 5'h1;
      err_ff <= (err_ff + 8'h1 >= err_gap_i) ? 8'h0 : err_ff + 8'h1;
    end
    if (rst_i) begin
      hist_o <= 64'h0;
      cnt_o <= 8'h00;
    end else if (div_ff == 4'h0) begin
      hist_o <= {hist_o[62:0], tx_data_i};
      cnt_o <= (cnt_o == 8'hFF) ? cnt_o : cnt_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
  end
module testbench;
  localparam int INTEG = 2000;
  localparam int LOOPC = 500;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        tx_clk_i;
  logic        tx_data_o;
  logic        rx_clk_i;
  logic        rx_data_i;
  logic        remote_loop_o;
  logic [15:0] pat = 16'h0000;
  logic [4:0]  plen = 5'h01;
  logic [7:0]  gap = 8'h00;
  logic [63:0] hist;
  logic [7:0]  cnt;
  int          n_fail = 0;
  int          n_checks = 0;
  logic [1:0]  t_sel [4] = '{ilcgd_pkg::TX_SEL_5, ilcgd_pkg::TX_SEL_6, ilcgd_pkg::TX_SEL_7, 2'h3};
  logic [7:0]  t_lo [4] = '{8'h80, 8'hA4, 8'hC8, 8'h96};
  logic [7:0]  t_hi [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h3C};
  logic [4:0]  t_len [4] = '{ilcgd_pkg::LEN_5, ilcgd_pkg::LEN_6, ilcgd_pkg::LEN_7, ilcgd_pkg::LEN_16};
  logic [7:0]  r_ctrl [4] = '{8'h22, 8'h22, 8'h39, 8'h39};
  logic [15:0] r_up [4] = '{16'h8000, 16'h8000, 16'h963C, 16'h963C};
  logic [15:0] r_dn [4] = '{16'hC000, 16'hC000, 16'h8000, 16'h8000};
  logic [15:0] r_pat [4] = '{16'h8000, 16'hC000, 16'h963C, 16'h8000};
  logic [4:0]  r_len [4] = '{5'h05, 5'h03, 5'h10, 5'h02};
  logic [7:0]  r_stat [4] = '{8'h80, 8'h40, 8'h80, 8'h40};

  ilcgd_top #(.INTEG_CYCLES(INTEG), .LOOP_CYCLES(LOOPC), .FIFO_DEPTH(4)) ilcgd_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_clk_i(tx_clk_i), .tx_data_o(tx_data_o),
    .rx_clk_i(rx_clk_i), .rx_data_i(rx_data_i), .remote_loop_o(remote_loop_o)
  );
  ilcgd_far_end ilcgd_far_end_i (
    .clk_i(clk_i), .rst_i(rst_i), .pat_i(pat), .len_i(plen), .err_gap_i(gap),
    .tx_data_i(tx_data_o), .tx_clk_o(tx_clk_i), .rx_clk_o(rx_clk_i), .rx_data_o(rx_data_i),
    .hist_o(hist), .cnt_o(cnt)
  );

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic wb(input logic we, input logic [5:0] idx, input logic [1:0] lo,
                    input logic [7:0] wd, input logic [3:0] sel, output logic [31:0] rd);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, lo};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_fail++;
      $display("bus answer missing at %0t", $time);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    wb(1'b1, idx, 2'h0, wd, 4'hF, rd);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    wb(1'b0, idx, 2'h0, 8'h00, 4'hF, rd);
    `CHECK(rd, {24'h0, exp})
  endtask

  initial begin
    repeat (90000) @(posedge clk_i);
    n_fail++;
    $display("watchdog expired at %0t", $time);
    stop_test();
  end

  initial begin
    logic [31:0] rd;
    logic [39:0] got;
    logic [39:0] exp;
    logic [15:0] code;
    int          j;
    do_reset();
    for (int i = 10; i <= 18; i++) rd_chk(6'(i), ilcgd_pkg::REG_RST);
    for (int i = 10; i <= 16; i++) wr(6'(i), 8'(i * 17));
    for (int i = 10; i <= 16; i++) rd_chk(6'(i), 8'(i * 17));
    wr(ilcgd_pkg::IDX_STATUS, 8'hFF);
    rd_chk(ilcgd_pkg::IDX_STATUS, 8'h00);
    // Byte lane 0 off must leave state untouched; unmapped and misaligned reads return zero
    wb(1'b1, ilcgd_pkg::IDX_TX_LO, 2'h0, 8'h5A, 4'hE, rd);
    rd_chk(ilcgd_pkg::IDX_TX_LO, 8'hBB);
    wb(1'b0, 6'h3F, 2'h0, 8'h00, 4'hF, rd);
    `CHECK(rd, 32'h0)
    wb(1'b0, ilcgd_pkg::IDX_CTRL, 2'h1, 8'h00, 4'hF, rd);
    `CHECK(rd, 32'h0)
    // Generator: fresh reset per length so the first one seen starts a repetition
    for (int c = 0; c < 4; c++) begin
      do_reset();
      wr(ilcgd_pkg::IDX_CTRL, {t_sel[c], 6'h00});
      wr(ilcgd_pkg::IDX_TX_LO, t_lo[c]);
      wr(ilcgd_pkg::IDX_TX_HI, t_hi[c]);
      wr(ilcgd_pkg::IDX_CONFIG, 8'h01);
      repeat (500) @(posedge clk_i);
      j = -1;
      for (int k = 0; k < 64; k++) if (k < cnt && hist[k] === 1'b1) j = k;
      code = {t_lo[c], t_hi[c]};
      for (int k = 0; k < 40; k++) begin
        got[39 - k] = (j - k >= 0) ? hist[j - k] : 1'bx;
        exp[39 - k] = code[15 - (k % t_len[c])];
      end
      `CHECK(got, exp)
    end
    // Detectors with one error per hundred bits on the line
    gap <= 8'h64;
    wr(ilcgd_pkg::IDX_CONFIG, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(ilcgd_pkg::IDX_CTRL, r_ctrl[c]);
      wr(ilcgd_pkg::IDX_UP_LO, r_up[c][15:8]);
      wr(ilcgd_pkg::IDX_UP_HI, r_up[c][7:0]);
      wr(ilcgd_pkg::IDX_DN_LO, r_dn[c][15:8]);
      wr(ilcgd_pkg::IDX_DN_HI, r_dn[c][7:0]);
      pat <= r_pat[c];
      plen <= r_len[c];
      repeat (4 * INTEG) @(posedge clk_i);
      rd_chk(ilcgd_pkg::IDX_STATUS, r_stat[c]);
    end
    // Automatic loopback: up code in, down code out, then disable
    wr(ilcgd_pkg::IDX_CONFIG, 8'h02);
    pat <= 16'h963C;
    plen <= 5'h10;
    repeat (4 * INTEG) @(posedge clk_i);
    `CHECK(remote_loop_o, 1'b1)
    rd_chk(ilcgd_pkg::IDX_STATUS, 8'h81);
    pat <= 16'h8000;
    plen <= 5'h02;
    repeat (4 * INTEG) @(posedge clk_i);
    `CHECK(remote_loop_o, 1'b0)
    pat <= 16'h963C;
    plen <= 5'h10;
    repeat (4 * INTEG) @(posedge clk_i);
    `CHECK(remote_loop_o, 1'b1)
    wr(ilcgd_pkg::IDX_CONFIG, 8'h00);
    repeat (2) @(posedge clk_i);
    `CHECK(remote_loop_o, 1'b0)
    stop_test();
  end
endmodule
`default_nettype wire
